// file: hdl/pcsi_core.sv
// pcsi_core: program counter, high-address latch, return stack and
// indirect data addressing of a small 8-bit core.
// assumes one event per cycle from the sequencer and same-clock inputs.
//
// Functional notes
// RULE_01 - 13-bit program counter drives fetch; its low byte is read/write
// RULE_02 - upper counter bits hidden; loaded from the high-address latch on a low-byte write
// RULE_03 - eight 13-bit stack entries, pointer invisible to software
// RULE_04 - call and interrupt branch push the counter
// RULE_05 - plain, literal and interrupt returns pop into the counter
// RULE_06 - push and pop leave the high-address latch untouched
// RULE_07 - stack is circular; ninth push overwrites first, no error
// RULE_08 - call and branch take 11 target bits, page bit from latch bit 3; code takes both page bits from latch bits 4:3
// RULE_09 - full counter stacked; returns need no page-bit change
// RULE_10 - indirect register has no storage, redirects through the pointer
// RULE_11 - indirect read with pointer zero returns 00h
// RULE_12 - indirect write with pointer zero changes nothing
// RULE_13 - 9-bit indirect address from bank bit and pointer; bank ignored
// RULE_14 - stack pointer wraps both ways; empty pop gives wrapped entry
// RULE_15 - interrupt pushes the address of the next instruction
//
// The address-and-strobe port and the register offsets were left to the implementer.
module pcsi_core
   import pcsi_pkg::*;
(
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  srst,

   // register port
   input  wire logic [REG_ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0]     reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [DATA_W-1:0]     reg_rdata,

   // sequencer events
   input  wire logic                  fetch_advance,
   input  wire logic                  call_op,
   input  wire logic                  uncond_branch_op,
   input  wire logic [TARGET_W-1:0]   branch_target,
   input  wire logic                  return_op,
   input  wire logic                  return_literal_op,
   input  wire logic                  interrupt_return_op,
   input  wire logic                  irq_take,

   // program memory fetch
   output logic      [PC_W-1:0]       fetch_addr,

   // data file
   output logic      [FADDR_W-1:0]    file_addr,
   output logic                       file_rd,
   output logic                       file_wr,
   output logic      [DATA_W-1:0]     file_wdata,
   input  wire logic [DATA_W-1:0]     file_rdata
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [PC_W-1:0]    program_counter;
   logic [PC_W-1:0]    next_program_counter;
   logic [LATCH_W-1:0] high_address_latch;
   logic [LATCH_W-1:0] next_high_address_latch;
   logic [DATA_W-1:0]  data_pointer_reg;
   logic [DATA_W-1:0]  next_data_pointer_reg;
   logic               indirect_bank_bit;
   logic               next_indirect_bank_bit;
   logic [DATA_W-1:0]  rdata_q;
   logic [DATA_W-1:0]  next_rdata;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic               wr_indirect;
   logic               wr_low;
   logic               wr_status;
   logic               wr_pointer;
   logic               wr_latch;
   logic               rd_indirect;
   logic               any_return;
   logic               do_push;
   logic               do_pop;
   logic [PC_W-1:0]    stack_top;
   logic [PC_W-1:0]    push_value;
   logic [PC_W-1:0]    page_target;
   logic               self_hit;

   assign wr_indirect = reg_wr & (reg_addr == OFS_INDIRECT);
   assign wr_low      = reg_wr & (reg_addr == OFS_LOW);
   assign wr_status   = reg_wr & (reg_addr == OFS_STATUS);
   assign wr_pointer  = reg_wr & (reg_addr == OFS_POINTER);
   assign wr_latch    = reg_wr & (reg_addr == OFS_LATCH);
   assign rd_indirect = reg_rd & (reg_addr == OFS_INDIRECT);

   // ----------------------------------------------------------------
   // stack control
   // ----------------------------------------------------------------
   // all three return kinds pop the same way
   assign any_return = return_op | return_literal_op
                     | interrupt_return_op; // RULE_05

   // interrupt has top priority, then call, then returns
   assign do_push = irq_take | call_op; // RULE_04
   // a branch outranks a return, so the dropped return must not pop
   assign do_pop  = any_return & ~do_push & ~uncond_branch_op; // RULE_05

   // counter already points past the current instruction, so the
   // value pushed is the next one to run in both cases
   assign push_value = program_counter; // RULE_09 RULE_15

   pcsi_stack u_stack (
      .ref_clk   (ref_clk),
      .srst      (srst),
      .push      (do_push),
      .pop       (do_pop),
      .push_addr (push_value),
      .top_addr  (stack_top)
   );

   // ----------------------------------------------------------------
   // program counter
   // ----------------------------------------------------------------
   // page bits 4:3 from latch, low eleven bits from the instruction
   assign page_target = {high_address_latch[LATCH_W-1:PAGE_BIT],
                         branch_target}; // RULE_08

   always_comb begin
      next_program_counter = program_counter;
      if (irq_take) begin
         next_program_counter = IRQ_VECTOR; // RULE_15
      end else if (call_op | uncond_branch_op) begin
         next_program_counter = page_target; // RULE_08 RULE_02
      end else if (any_return) begin
         // full address restored, latch not consulted
         next_program_counter = stack_top; // RULE_05 RULE_09
      end else if (wr_low) begin
         // a low-byte write also loads the hidden upper bits
         next_program_counter = {high_address_latch,
                                 reg_wdata}; // RULE_01 RULE_02
      end else if (fetch_advance) begin
         next_program_counter = program_counter + 13'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         program_counter <= PC_RESET;
      end else begin
         program_counter <= next_program_counter;
      end
   end

   assign fetch_addr = program_counter; // RULE_01

   // ----------------------------------------------------------------
   // high-address latch
   // ----------------------------------------------------------------
   // only a software write moves it; push and pop never do
   always_comb begin
      next_high_address_latch = high_address_latch;
      if (wr_latch) begin
         next_high_address_latch = reg_wdata[LATCH_W-1:0]; // RULE_06
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         high_address_latch <= LATCH_RESET;
      end else begin
         high_address_latch <= next_high_address_latch;
      end
   end

   // ----------------------------------------------------------------
   // pointer and bank bit
   // ----------------------------------------------------------------
   always_comb begin
      next_data_pointer_reg  = data_pointer_reg;
      next_indirect_bank_bit = indirect_bank_bit;
      if (wr_pointer) begin
         next_data_pointer_reg = reg_wdata;
      end
      if (wr_status) begin
         // kept for software, but it never reaches the address
         next_indirect_bank_bit = reg_wdata[BANK_BIT]; // RULE_13
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         data_pointer_reg  <= POINTER_RESET;
         indirect_bank_bit <= BANK_RESET;
      end else begin
         data_pointer_reg  <= next_data_pointer_reg;
         indirect_bank_bit <= next_indirect_bank_bit;
      end
   end

   // ----------------------------------------------------------------
   // indirect access
   // ----------------------------------------------------------------
   pcsi_indirect u_indirect (
      .pointer   (data_pointer_reg),
      .bank      (indirect_bank_bit),
      .acc_rd    (rd_indirect),
      .acc_wr    (wr_indirect),
      .file_addr (file_addr),
      .file_rd   (file_rd),
      .file_wr   (file_wr),
      .self_hit  (self_hit)
   );

   // write data goes straight through; the strobe alone guards it
   assign file_wdata = reg_wdata; // RULE_10

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   // upper counter bits and stack pointer have no read path
   always_comb begin
      next_rdata = UNMAPPED_READ;
      if (reg_rd) begin
         case (reg_addr)
            OFS_INDIRECT: begin
               if (self_hit) begin
                  next_rdata = SELF_READ; // RULE_11
               end else begin
                  next_rdata = file_rdata; // RULE_10
               end
            end
            OFS_LOW: begin
               next_rdata = program_counter[LOW_W-1:0]; // RULE_01
            end
            OFS_STATUS: begin
               next_rdata = {indirect_bank_bit, 7'h00};
            end
            OFS_POINTER: begin
               next_rdata = data_pointer_reg;
            end
            OFS_LATCH: begin
               next_rdata = {3'h0, high_address_latch};
            end
            default: begin
               next_rdata = UNMAPPED_READ;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdata_q <= UNMAPPED_READ;
      end else begin
         rdata_q <= next_rdata;
      end
   end

   assign reg_rdata = rdata_q;

endmodule : pcsi_core

// file: include/pcsi_pkg.sv
// pcsi_pkg: widths, register offsets, reset values and fixed
// addresses shared by the program counter, stack and indirect units.
// assumes a single core clock and a synchronous active-high reset.
package pcsi_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int PC_W       = 13;
   localparam int LOW_W      = 8;
   localparam int LATCH_W    = 5;
   localparam int TARGET_W   = 11;
   localparam int DATA_W     = 8;
   localparam int FADDR_W    = 9;
   localparam int REG_ADDR_W = 4;
   localparam int STACK_DEPTH = 8;
   localparam int SP_W       = 3;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int PAGE_BIT   = 3;
   localparam int BANK_BIT   = 7;

   // ----------------------------------------------------------------
   // register offsets on the plain register port
   // ----------------------------------------------------------------
   localparam logic [REG_ADDR_W-1:0] OFS_INDIRECT = 4'h0;
   localparam logic [REG_ADDR_W-1:0] OFS_LOW      = 4'h1;
   localparam logic [REG_ADDR_W-1:0] OFS_STATUS   = 4'h2;
   localparam logic [REG_ADDR_W-1:0] OFS_POINTER  = 4'h3;
   localparam logic [REG_ADDR_W-1:0] OFS_LATCH    = 4'h4;

   // ----------------------------------------------------------------
   // reset values and fixed addresses
   // ----------------------------------------------------------------
   localparam logic [PC_W-1:0]    PC_RESET      = 13'h0000;
   localparam logic [LATCH_W-1:0] LATCH_RESET   = 5'h00;
   localparam logic [DATA_W-1:0]  POINTER_RESET = 8'h00;
   localparam logic               BANK_RESET    = 1'b0;
   localparam logic [SP_W-1:0]    SP_RESET      = 3'h0;
   localparam logic [PC_W-1:0]    IRQ_VECTOR    = 13'h0004;
   localparam logic [DATA_W-1:0]  SELF_POINTER  = 8'h00;
   localparam logic [DATA_W-1:0]  SELF_READ     = 8'h00;
   localparam logic [DATA_W-1:0]  UNMAPPED_READ = 8'h00;
   // on this part the bank bit takes no part in the address
   localparam logic               BANK_USED     = 1'b0;

endpackage : pcsi_pkg

// file: hdl/pcsi_stack.sv
// pcsi_stack: eight-entry circular return-address stack.
// assumes push and pop are never asked in the same cycle; push wins.
module pcsi_stack
   import pcsi_pkg::*;
(
   // clock and reset
   input  wire logic            ref_clk,
   input  wire logic            srst,
   // requests
   input  wire logic            push,
   input  wire logic            pop,
   input  wire logic [PC_W-1:0] push_addr,
   // answer
   output logic      [PC_W-1:0] top_addr
);

   logic [PC_W-1:0] entry [STACK_DEPTH];
   logic [SP_W-1:0] sp;
   logic [SP_W-1:0] next_sp;
   logic [SP_W-1:0] below;

   // ----------------------------------------------------------------
   // pointer
   // ----------------------------------------------------------------
   assign below = sp - 3'h1;
   // entry under the pointer, read out even on an empty stack
   assign top_addr = entry[below]; // RULE_14

   always_comb begin
      next_sp = sp;
      if (push) begin
         next_sp = sp + 3'h1; // RULE_07
      end else if (pop) begin
         next_sp = below; // RULE_14
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sp <= SP_RESET;
      end else begin
         sp <= next_sp;
      end
   end

   // ----------------------------------------------------------------
   // storage, no reset: contents are undefined until pushed
   // ----------------------------------------------------------------
   // ninth push lands on slot of first, no overflow flag
   always_ff @(posedge ref_clk) begin
      if (push) begin
         entry[sp] <= push_addr; // RULE_03 RULE_07
      end
   end

endmodule : pcsi_stack

// file: hdl/pcsi_indirect.sv
// pcsi_indirect: redirects accesses of the virtual indirect register
// to the data file through the pointer register.
// assumes the data file answers reads combinationally in the same cycle.
module pcsi_indirect
   import pcsi_pkg::*;
(
   // pointer state
   input  wire logic [DATA_W-1:0]  pointer,
   input  wire logic               bank,
   // access to the virtual register
   input  wire logic               acc_rd,
   input  wire logic               acc_wr,
   // redirected access
   output logic      [FADDR_W-1:0] file_addr,
   output logic                    file_rd,
   output logic                    file_wr,
   output logic                    self_hit
);

   // ----------------------------------------------------------------
   // address forming
   // ----------------------------------------------------------------
   assign file_addr = {bank & BANK_USED, pointer}; // RULE_13
   assign self_hit  = (pointer == SELF_POINTER);

   // pointing at itself reaches nothing: no read, no write
   assign file_rd = acc_rd & ~self_hit; // RULE_10 RULE_11
   assign file_wr = acc_wr & ~self_hit; // RULE_10 RULE_12

endmodule : pcsi_indirect

// file: dv/pcsi_file_model.sv
// pcsi_file_model: data register file behind the indirect path.
// assumes the core asks one byte per cycle and reads combinationally.
module pcsi_file_model
   import pcsi_pkg::*;
(
   // clock
   input  wire logic               ref_clk,
   // access from the core
   input  wire logic [FADDR_W-1:0] file_addr,
   input  wire logic               file_rd,
   input  wire logic               file_wr,
   input  wire logic [DATA_W-1:0]  file_wdata,
   output logic      [DATA_W-1:0]  file_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [1<<FADDR_W];
   logic [DATA_W-1:0] last = 8'h00;
   // idle answer is the inverse of the last one, so a stale sample shows
   assign file_rdata = file_rd ? mem[file_addr] : ~last;
   always @(posedge ref_clk) begin
      if (file_wr) begin
         mem[file_addr] <= file_wdata;
      end
      if (file_rd) begin
         last <= mem[file_addr];
      end
   end
endmodule : pcsi_file_model

// file: dv/pcsi_core_chk.sv
// pcsi_core_chk: port assertions for pcsi_core.
// assumes one clock and the synchronous reset srst.
module pcsi_core_chk
   import pcsi_pkg::*;
(
   // clock and reset
   input wire logic                  ref_clk,
   input wire logic                  srst,
   // register port
   input wire logic [REG_ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0]     reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [DATA_W-1:0]     reg_rdata,
   // sequencer events
   input wire logic                  fetch_advance,
   input wire logic                  call_op,
   input wire logic                  uncond_branch_op,
   input wire logic [TARGET_W-1:0]   branch_target,
   input wire logic                  return_op,
   input wire logic                  return_literal_op,
   input wire logic                  interrupt_return_op,
   input wire logic                  irq_take,
   // fetch and data file
   input wire logic [PC_W-1:0]       fetch_addr,
   input wire logic [FADDR_W-1:0]    file_addr,
   input wire logic                  file_rd,
   input wire logic                  file_wr,
   input wire logic [DATA_W-1:0]     file_wdata,
   input wire logic [DATA_W-1:0]     file_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // shadow of the software-visible latch and pointer
   // ----------------------------------------------------------------
   logic [LATCH_W-1:0] latch;
   logic [LATCH_W-1:0] next_latch;
   logic [DATA_W-1:0]  ptr;
   logic [DATA_W-1:0]  next_ptr;
   logic               quiet;
   assign quiet = !(call_op || uncond_branch_op || return_op || return_literal_op || interrupt_return_op || irq_take);
   always_comb begin
      next_latch = (reg_wr && reg_addr == OFS_LATCH) ? reg_wdata[LATCH_W-1:0] : latch;
      next_ptr   = (reg_wr && reg_addr == OFS_POINTER) ? reg_wdata : ptr;
   end
   always_ff @(posedge ref_clk) begin
      latch <= srst ? LATCH_RESET : next_latch;
      ptr   <= srst ? POINTER_RESET : next_ptr;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   sequence call_s;
      call_op && !irq_take;
   endsequence
   sequence ret_s;
      (return_op || return_literal_op || interrupt_return_op) && !call_op && !uncond_branch_op && !irq_take;
   endsequence
   step_up_a: assert property (quiet && fetch_advance && !(reg_wr && reg_addr == OFS_LOW)
      |=> fetch_addr == $past(fetch_addr) + 13'h0001) else $error("fetch address did not step");
   low_load_a: assert property (quiet && reg_wr && reg_addr == OFS_LOW
      |=> fetch_addr == {$past(latch), $past(reg_wdata)}) else $error("low byte write load wrong");
   page_jump_a: assert property ((call_op || uncond_branch_op) && !irq_take
      |=> fetch_addr == {$past(latch[LATCH_W-1:PAGE_BIT]), $past(branch_target)}) else $error("branch target wrong");
   vector_a: assert property (irq_take |=> fetch_addr == IRQ_VECTOR) else $error("vector not loaded");
   call_back_a: assert property (call_s ##1 ret_s
      |=> fetch_addr == $past(fetch_addr, 2)) else $error("return address wrong");
   self_read_a: assert property (reg_rd && reg_addr == OFS_INDIRECT && ptr == SELF_POINTER
      |-> !file_rd ##1 reg_rdata == SELF_READ) else $error("self read not zero");
   self_write_a: assert property (reg_wr && reg_addr == OFS_INDIRECT && ptr == SELF_POINTER
      |-> !file_wr) else $error("self write reached file");
   redirect_a: assert property (reg_rd && reg_addr == OFS_INDIRECT && ptr != SELF_POINTER
      |-> file_rd ##1 reg_rdata == $past(file_rdata)) else $error("indirect read not redirected");
   file_addr_a: assert property (file_addr == {1'b0, ptr}) else $error("file address wrong");
endmodule : pcsi_core_chk

bind pcsi_core pcsi_core_chk i_chk (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_advance(fetch_advance), .call_op(call_op),
   .uncond_branch_op(uncond_branch_op), .branch_target(branch_target), .return_op(return_op),
   .return_literal_op(return_literal_op), .interrupt_return_op(interrupt_return_op), .irq_take(irq_take),
   .fetch_addr(fetch_addr), .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr),
   .file_wdata(file_wdata), .file_rdata(file_rdata));

// file: dv/tb_top.sv
// tb_top: self-checking bench for pcsi_core with a data file model.
// assumes the checker is bound in by its own file.
module tb_top
   import pcsi_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int EV_ADV = 0, EV_CALL = 1, EV_JMP = 2, EV_RET = 3, EV_RETI = 5, EV_IRQ = 6;
   typedef struct packed {
      logic [REG_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]     wdata;
      logic [DATA_W-1:0]     rdval;
   } pcsi_row_t;
   localparam pcsi_row_t ROWS [6] = '{
      '{OFS_POINTER, 8'h5a, 8'h5a},
      '{OFS_LATCH, 8'hff, 8'h1f},
      '{OFS_STATUS, 8'hff, 8'h80},
      '{4'h5, 8'hff, 8'h00},
      '{4'hf, 8'hff, 8'h00},
      '{OFS_LOW, 8'h34, 8'h34}};
   logic                  ref_clk;
   logic                  srst;
   logic [REG_ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0]     reg_wdata;
   logic                  reg_wr;
   logic                  reg_rd;
   logic [DATA_W-1:0]     reg_rdata;
   logic [DATA_W-1:0]     rd_val;
   logic [6:0]            evs;
   logic [TARGET_W-1:0]   branch_target;
   logic [PC_W-1:0]       fetch_addr;
   logic [FADDR_W-1:0]    file_addr;
   logic                  file_rd;
   logic                  file_wr;
   logic [DATA_W-1:0]     file_wdata;
   logic [DATA_W-1:0]     file_rdata;
   int                    miscompares = 0;
   int                    comparisons = 0;
   int                    cycles = 0;
   pcsi_core i_dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_advance(evs[0]), .call_op(evs[1]), .uncond_branch_op(evs[2]),
      .branch_target(branch_target), .return_op(evs[3]), .return_literal_op(evs[4]), .interrupt_return_op(evs[5]),
      .irq_take(evs[6]), .fetch_addr(fetch_addr), .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr),
      .file_wdata(file_wdata), .file_rdata(file_rdata));
   pcsi_file_model i_file (.ref_clk(ref_clk), .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr),
      .file_wdata(file_wdata), .file_rdata(file_rdata));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ----------------------------------------------------------------
   // drivers, compares and verdict
   // ----------------------------------------------------------------
   task automatic chk8(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8
   task automatic chk13(input string what, input logic [PC_W-1:0] exp);
      comparisons++;
      if (fetch_addr !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, fetch_addr);
      end
   endtask : chk13
   task automatic reg_write(input logic [REG_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [REG_ADDR_W-1:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask : reg_read
   task automatic pulse(input int k, input logic [TARGET_W-1:0] t);
      @(posedge ref_clk);
      evs[k] <= 1'b1;
      branch_target <= t;
      @(posedge ref_clk);
      evs <= 7'h00;
      #1;
   endtask : pulse
   task automatic give_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict
   // run is about 130 cycles; the ceiling leaves wide margin
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         give_verdict();
      end
   end
   initial begin
      {srst, reg_wr, reg_rd, reg_addr, reg_wdata, evs, branch_target} = '0;
      srst = 1'b1;
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      #1;
      chk13("reset fetch", PC_RESET);
      foreach (ROWS[i]) begin
         reg_write(ROWS[i].addr, ROWS[i].wdata);
         reg_read(ROWS[i].addr);
         chk8("row read", ROWS[i].rdval, rd_val);
      end
      chk13("low load", 13'h1f34);
      reg_write(OFS_LATCH, 8'h08);
      pulse(EV_JMP, 11'h7ff);
      chk13("page jump", 13'h0fff);
      // nine calls: the ninth overwrites the first slot silently
      reg_write(OFS_LATCH, 8'h10);
      for (int i = 0; i < 9; i++) begin
         pulse(EV_JMP, TARGET_W'(i * 16 + 1));
         pulse(EV_CALL, 11'h700);
         chk13("call target", 13'h1700);
      end
      for (int k = 0; k < 8; k++) begin
         pulse(EV_RET + k % 3, 11'h000);
         chk13("pop", PC_W'(13'h1000 + (8 - k) * 16 + 1));
      end
      pulse(EV_RET, 11'h000);
      chk13("empty pop", 13'h1081);
      reg_read(OFS_LATCH);
      chk8("latch kept", 8'h10, rd_val);
      pulse(EV_ADV, 11'h000);
      pulse(EV_IRQ, 11'h000);
      chk13("vector", IRQ_VECTOR);
      pulse(EV_ADV, 11'h000);
      pulse(EV_RETI, 11'h000);
      chk13("irq resume", 13'h1082);
      // call and return on adjacent edges: the popped entry was written one edge before
      @(posedge ref_clk);
      evs <= 7'h02;
      branch_target <= 11'h123;
      @(posedge ref_clk);
      evs <= 7'h08;
      #1;
      chk13("back call", 13'h1123);
      @(posedge ref_clk);
      evs <= 7'h00;
      #1;
      chk13("back return", 13'h1082);
      reg_write(OFS_POINTER, 8'h05);
      reg_write(OFS_INDIRECT, 8'h10);
      reg_write(OFS_POINTER, 8'h06);
      reg_write(OFS_INDIRECT, 8'h0a);
      reg_write(OFS_STATUS, 8'h80);
      reg_read(OFS_INDIRECT);
      chk8("indirect 6", 8'h0a, rd_val);
      reg_write(OFS_POINTER, 8'h00);
      reg_write(OFS_INDIRECT, 8'h77);
      reg_read(OFS_INDIRECT);
      chk8("self read", SELF_READ, rd_val);
      reg_write(OFS_POINTER, 8'h05);
      reg_read(OFS_INDIRECT);
      chk8("indirect 5", 8'h10, rd_val);
      @(posedge ref_clk);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      #1;
      chk13("second reset", PC_RESET);
      reg_read(OFS_POINTER);
      chk8("reset pointer", POINTER_RESET, rd_val);
      give_verdict();
   end
endmodule : tb_top
